/* rtl/csd_params.svh */
// Constants of the configuration strap decoder: strap positions,
// register byte addresses, field positions and reset values.
// Assumes a 20-lane strap bus and a 32-bit AXI4-Lite register port.
`ifndef CSD_PARAMS_SVH
`define CSD_PARAMS_SVH

`define CSD_STRAP_W 20
`define CSD_ADDR_W 12
`define CSD_STRAP_RST 20'hfffff
`define CSD_FUNC_MASK 20'h0007c
`define CSD_BIT_LANE 2
`define CSD_BIT_DBG 3
`define CSD_BIT_DISP 4
`define CSD_BIT_BIF_LO 5
`define CSD_BIT_BIF_HI 6
`define CSD_BIF_X8_X4X4 2'h0
`define CSD_BIF_RSVD 2'h1
`define CSD_BIF_X8X8 2'h2
`define CSD_BIF_X16 2'h3

`define CSD_ADR_STRAP 12'h000
`define CSD_ADR_SETTING 12'h004
`define CSD_ADR_DBG_OPT 12'hc80
`define CSD_SET_LANE 0
`define CSD_SET_DBG 1
`define CSD_SET_DISP 2
`define CSD_SET_BIF_LO 3
`define CSD_SET_BIF_HI 4
`define CSD_SET_BIFRSV 5
`define CSD_SET_VALID 8
`define CSD_DBG_RST 1'h0
`define CSD_RESP_OKAY 2'h0
`define CSD_RESP_SLVERR 2'h2

`endif

/* rtl/csd_pkg.sv */
// Types of the configuration strap decoder: bus carriers and states.
// Assumes csd_params.svh is on the include path.
`include "csd_params.svh"

package csd_pkg;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [`CSD_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`CSD_ADDR_W-1:0] araddr;
        logic rready;
    } csd_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } csd_axi_rsp_t;

    // Capture sequence after reset release
    typedef enum logic [1:0] {
        CSD_ARMED,
        CSD_LATCHED,
        CSD_SETTLED
    } csd_state_t;

    // Register select
    typedef enum logic [1:0] {
        CSD_SEL_STRAP,
        CSD_SEL_SETTING,
        CSD_SEL_DBG,
        CSD_SEL_NONE
    } csd_sel_t;

endpackage

/* rtl/csd_top.sv */
// Configuration strap decoder: latches board straps once after reset
// and drives static lane, display and bifurcation settings and a debug bit that software may rewrite.
// Assumes straps are synchronous to mclk and steady around reset release.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "csd_params.svh"

module csd_top
    import csd_pkg::*;
#(
    parameter int STRAP_W = `CSD_STRAP_W,
    parameter int ADDR_W = `CSD_ADDR_W
)
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [STRAP_W-1:0] strap_i,
    input wire csd_axi_req_t axi_req,
    output csd_axi_rsp_t axi_rsp,
    output logic lane_reverse_q,
    output logic debug_enable_q,
    output logic disp_enable_q,
    output logic [1:0] bifurc_q,
    output logic settings_valid_q
);

    // The register map and field positions are fixed at these widths
    if (STRAP_W != `CSD_STRAP_W || ADDR_W != `CSD_ADDR_W)
    begin : g_bad_param
        $error("csd_top: strap or address width not supported");
    end

    // Address decode shared by both bus directions
    function automatic csd_sel_t csd_sel(input logic [ADDR_W-1:0] a);
        csd_sel_t s;
        s = CSD_SEL_NONE;
        if (a == `CSD_ADR_STRAP)
            s = CSD_SEL_STRAP;
        else if (a == `CSD_ADR_SETTING)
            s = CSD_SEL_SETTING;
        else if (a == `CSD_ADR_DBG_OPT)
            s = CSD_SEL_DBG;
        return s;
    endfunction

    // Bifurcation decode; reserved code falls back to one x16 link
    function automatic logic [1:0] csd_bif(input logic [1:0] code);
        logic [1:0] b;
        b = code;
        if (code == `CSD_BIF_RSVD)
            b = `CSD_BIF_X16;
        return b;
    endfunction

    csd_state_t state_q, state_d;
    logic [STRAP_W-1:0] strap_q, strap_d;
    logic lane_d, dbg_d, disp_d, valid_d, bifrsv_q, bifrsv_d;
    logic [1:0] bif_d;

    // Capture sequence and decoded settings
    always_comb
    begin
        state_d = state_q;
        strap_d = strap_q;
        lane_d = lane_reverse_q;
        disp_d = disp_enable_q;
        bif_d = bifurc_q;
        bifrsv_d = bifrsv_q;
        valid_d = settings_valid_q;
        unique case (state_q)
            CSD_ARMED:
            begin
                // Reserved lanes are dropped here so nothing can use them
                strap_d = strap_i & `CSD_FUNC_MASK;
                state_d = CSD_LATCHED;
            end
            CSD_LATCHED:
            begin
                lane_d = ~strap_q[`CSD_BIT_LANE];
                disp_d = ~strap_q[`CSD_BIT_DISP];
                bif_d = csd_bif(strap_q[`CSD_BIT_BIF_HI:`CSD_BIT_BIF_LO]);
                bifrsv_d = strap_q[`CSD_BIT_BIF_HI:`CSD_BIT_BIF_LO]
                    == `CSD_BIF_RSVD;
                valid_d = 1'b1;
                state_d = CSD_SETTLED;
            end
            CSD_SETTLED:
            begin
                state_d = CSD_SETTLED;
            end
        endcase
    end

    // Reset values carry the all-ones strap meaning until capture
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= CSD_ARMED;
            strap_q <= `CSD_STRAP_RST;
            lane_reverse_q <= 1'b0;
            disp_enable_q <= 1'b0;
            bifurc_q <= `CSD_BIF_X16;
            bifrsv_q <= 1'b0;
            settings_valid_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            strap_q <= strap_d;
            lane_reverse_q <= lane_d;
            disp_enable_q <= disp_d;
            bifurc_q <= bif_d;
            bifrsv_q <= bifrsv_d;
            settings_valid_q <= valid_d;
        end
    end

    // AXI4-Lite slave state
    logic aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic dbg_wr;
    csd_axi_rsp_t rsp_d;
    logic [31:0] setting_word;

    // Settings as software sees them
    always_comb
    begin
        setting_word = 32'h0;
        setting_word[`CSD_SET_LANE] = lane_reverse_q;
        setting_word[`CSD_SET_DBG] = debug_enable_q;
        setting_word[`CSD_SET_DISP] = disp_enable_q;
        setting_word[`CSD_SET_BIF_HI:`CSD_SET_BIF_LO] = bifurc_q;
        setting_word[`CSD_SET_BIFRSV] = bifrsv_q;
        setting_word[`CSD_SET_VALID] = settings_valid_q;
    end

    // Address and data are taken in either order, then answered together
    always_comb
    begin
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        rsp_d = axi_rsp;
        dbg_wr = 1'b0;
        rsp_d.awready = 1'b0;
        rsp_d.wready = 1'b0;
        rsp_d.arready = 1'b0;
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            aw_held_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            w_held_d = 1'b1;
            wdata_d = axi_req.wdata;
            wstrb_d = axi_req.wstrb;
        end
        if (axi_rsp.bvalid && axi_req.bready)
            rsp_d.bvalid = 1'b0;
        // One cycle after both halves are held the write lands
        if (aw_held_q && w_held_q && !axi_rsp.bvalid)
        begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp = `CSD_RESP_OKAY;
            if (csd_sel(awaddr_q) == CSD_SEL_NONE)
                rsp_d.bresp = `CSD_RESP_SLVERR;
            dbg_wr = csd_sel(awaddr_q) == CSD_SEL_DBG && wstrb_q[0];
        end
        // Ready is offered one cycle ahead, only for an empty holder
        rsp_d.awready = !aw_held_d && !axi_rsp.awready
            && !(axi_req.awvalid && axi_rsp.awready);
        rsp_d.wready = !w_held_d && !axi_rsp.wready
            && !(axi_req.wvalid && axi_rsp.wready);
        // Read: one address at a time, data the cycle after acceptance
        if (axi_rsp.rvalid && axi_req.rready)
            rsp_d.rvalid = 1'b0;
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rresp = `CSD_RESP_OKAY;
            unique case (csd_sel(axi_req.araddr))
                CSD_SEL_STRAP: rsp_d.rdata = 32'(strap_q);
                CSD_SEL_SETTING: rsp_d.rdata = setting_word;
                CSD_SEL_DBG: rsp_d.rdata = {31'h0, debug_enable_q};
                CSD_SEL_NONE:
                begin
                    rsp_d.rdata = 32'h0;
                    rsp_d.rresp = `CSD_RESP_SLVERR;
                end
            endcase
        end
        rsp_d.arready = !rsp_d.rvalid && !axi_rsp.arready;
    end

    // Debug opt-in bit: strap sets its default, software may rewrite it
    always_comb
    begin
        dbg_d = debug_enable_q;
        if (state_q == CSD_ARMED)
            dbg_d = ~strap_i[`CSD_BIT_DBG];
        else if (dbg_wr)
            dbg_d = wdata_q[0];
    end

    // Bus and opt-in registers
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            axi_rsp <= '0;
            debug_enable_q <= `CSD_DBG_RST;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            axi_rsp <= rsp_d;
            debug_enable_q <= dbg_d;
        end
    end

    // Defaults hold until the decode has run
    chk_default_ones: assert property (
        @(posedge mclk) disable iff (!nrst)
        !settings_valid_q |-> !lane_reverse_q && !disp_enable_q
            && bifurc_q == `CSD_BIF_X16)
        else $error("settings left default before capture");

    chk_lane_order: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(settings_valid_q) |->
            lane_reverse_q == !strap_q[`CSD_BIT_LANE])
        else $error("lane reversal does not follow strap");

    chk_debug_default: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_q == CSD_ARMED ##1 state_q == CSD_LATCHED |->
            debug_enable_q == !strap_q[`CSD_BIT_DBG])
        else $error("debug default not taken from strap");

    chk_display_enable: assert property (
        @(posedge mclk) disable iff (!nrst)
        $rose(settings_valid_q) |->
            disp_enable_q == !strap_q[`CSD_BIT_DISP])
        else $error("display enable does not follow strap");

    chk_bifurc_map: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_q == CSD_LATCHED |=>
            bifurc_q == (($past(strap_q[6:5]) == `CSD_BIF_RSVD)
                ? `CSD_BIF_X16 : $past(strap_q[6:5]))
            && bifrsv_q == ($past(strap_q[6:5]) == `CSD_BIF_RSVD))
        else $error("bifurcation decode wrong");

    chk_rsv_masked: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_q != CSD_ARMED |-> (strap_q & ~`CSD_FUNC_MASK) == '0)
        else $error("reserved strap lane was kept");

    chk_hold_static: assert property (
        @(posedge mclk) disable iff (!nrst)
        settings_valid_q |=> settings_valid_q && $stable(strap_q)
            && $stable(lane_reverse_q) && $stable(disp_enable_q)
            && $stable(bifurc_q))
        else $error("settings changed after capture");

    // The release edge itself still sees reset, so allow one extra cycle
    chk_settle_time: assert property (
        @(posedge mclk) disable iff (!nrst)
        state_q == CSD_ARMED |-> ##[2:3] settings_valid_q)
        else $error("settings not valid two cycles after release");

    // A software write to the opt-in bit lands one edge after it is due
    chk_debug_write: assert property (
        @(posedge mclk) disable iff (!nrst)
        dbg_wr |=> debug_enable_q == $past(wdata_q[0]))
        else $error("opt-in bit write lost");

    // Write ready is only offered to an empty holder
    chk_aw_refuse: assert property (
        @(posedge mclk) disable iff (!nrst)
        (axi_rsp.awready |-> !aw_held_q)
        and (axi_rsp.wready |-> !w_held_q))
        else $error("write ready offered to a full holder");

    // No new read address while read data is still standing
    chk_ar_refuse: assert property (
        @(posedge mclk) disable iff (!nrst)
        axi_rsp.arready |-> !axi_rsp.rvalid)
        else $error("read address offered while data pending");

    // Read data follows acceptance by one edge
    chk_read_answer: assert property (
        @(posedge mclk) disable iff (!nrst)
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read data late after address taken");

endmodule // csd_top

/* verif/csd_strap_board.sv */
// Board side of the strap lanes: terminated lanes carry a level.
// Assumes the bench picks which lanes are terminated and to what.
`timescale 1ns/1ps
module csd_strap_board
(
    input wire logic [19:0] term_en,
    input wire logic [19:0] term_lvl,
    output logic [19:0] strap
);
    // Open lanes sit on the pull-up, reserved lanes may stay open too
    assign strap = (term_lvl & term_en) | ~term_en;
endmodule // csd_strap_board

/* verif/config_strap_decoder_test.sv */
// Self-checking bench of the strap decoder with an AXI4-Lite master.
// Assumes csd_params.svh on the include path and the board model.
`timescale 1ns/1ps
`include "csd_params.svh"
module config_strap_decoder_test
    import csd_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [19:0] term_en = '0;
    logic [19:0] term_lvl = '0;
    logic [19:0] strap;
    logic [19:0] last_s;
    logic [31:0] q;
    logic [31:0] d;
    logic [1:0] r;
    csd_axi_req_t req = '0;
    csd_axi_rsp_t rsp;
    logic lrev, dbg, disp, valid;
    logic [1:0] bif;
    int fails = 0;
    int tests_run = 0;
    always #4 mclk = ~mclk;
    csd_strap_board u_board (.term_en(term_en), .term_lvl(term_lvl),
        .strap(strap));
    csd_top u_dut (.mclk(mclk), .nrst(nrst), .strap_i(strap),
        .axi_req(req), .axi_rsp(rsp), .lane_reverse_q(lrev),
        .debug_enable_q(dbg), .disp_enable_q(disp), .bifurc_q(bif),
        .settings_valid_q(valid));
    // Verdict in one place so a timeout ends the same way
    task end_of_test();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task hang();
        fails++;
        $display("MISMATCH t=%0t bus answer never came", $time);
        end_of_test();
    endtask
    // Settings word expected from the straps seen at reset release
    function automatic logic [31:0] exp_set(input logic [19:0] s);
        logic [1:0] b;
        b = (s[6:5] == 2'h1) ? 2'h3 : s[6:5];
        exp_set = {23'h0, 1'b1, 2'h0, s[6:5] == 2'h1, b, ~s[4], ~s[3],
            ~s[2]};
    endfunction
    // Write: address and data offered together, each dropped once taken
    task axw(input logic [11:0] a, input logic [31:0] v,
        output logic [1:0] resp);
        int n;
        @(posedge mclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= v;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge mclk);
            if (req.awvalid && rsp.awready === 1'b1)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready === 1'b1)
                req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1)
                break;
        end
        if (n == 50)
            hang();
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task axr(input logic [11:0] a, output logic [31:0] v,
        output logic [1:0] resp);
        int n;
        @(posedge mclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (n = 0; n < 50; n++)
        begin
            @(posedge mclk);
            if (req.arvalid && rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1)
                break;
        end
        if (n == 50)
            hang();
        v = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    // Reset with given terminations, then check ports and registers
    task run_case(input logic [19:0] en, input logic [19:0] lvl);
        logic [31:0] e;
        logic [31:0] p;
        last_s = (lvl & en) | ~en;
        e = exp_set(last_s);
        p = {26'h0, e[0], e[1], e[2], e[4:3], e[8]};
        @(posedge mclk);
        term_en <= en;
        term_lvl <= lvl;
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp({26'h0, lrev, dbg, disp, bif, valid}, p);
        axr(`CSD_ADR_SETTING, q, r);
        cmp(q, e);
        axr(`CSD_ADR_STRAP, q, r);
        cmp(q, {12'h0, last_s & `CSD_FUNC_MASK});
        // Straps moving after release must leave settings alone
        term_en <= '1;
        term_lvl <= ~lvl;
        repeat (4) @(posedge mclk);
        cmp({26'h0, lrev, dbg, disp, bif, valid}, p);
    endtask
    initial
    begin
        d = $urandom(32'h161c);
        run_case(20'h0, 20'h0);
        // Every bifurcation code, other lanes random
        for (int i = 0; i < 8; i++)
            run_case(20'($urandom) | 20'h60,
                {13'($urandom), i[1:0], 5'h0});
        for (int k = 0; k < 2; k++)
        begin
            d = {$urandom} & 32'hfffffffe | k;
            axw(`CSD_ADR_DBG_OPT, d, r);
            cmp(32'(r), 32'(`CSD_RESP_OKAY));
            axr(`CSD_ADR_DBG_OPT, q, r);
            cmp(q, k);
            cmp(32'(dbg), k);
        end
        // Read-only and unmapped places
        axw(`CSD_ADR_STRAP, 32'hffffffff, r);
        cmp(32'(r), 32'(`CSD_RESP_OKAY));
        axr(`CSD_ADR_STRAP, q, r);
        cmp(q, {12'h0, last_s & `CSD_FUNC_MASK});
        axw(12'h010, $urandom, r);
        cmp(32'(r), 32'(`CSD_RESP_SLVERR));
        axr(12'h010, q, r);
        cmp(q, 32'h0);
        cmp(32'(r), 32'(`CSD_RESP_SLVERR));
        end_of_test();
    end
endmodule // config_strap_decoder_test
